/* hdl/cog_instruction_pipeline.sv */
`timescale 1ns/1ps
`include "cog_pipe_regs.svh"

// Contract
// - five stages over six overlapping cycles
// - one instruction every four cycles
// - cycle M fetches instruction at pc
// - cycle M+1 writes previous instruction result
// - immediate flag uses source field, no read
// - otherwise read source operand in M+2
// - read destination operand in M+3
// - M+4 executes while next fetch proceeds
// - M+5 writes result back to memory
// - modifying next instruction runs old copy
// - conditional jumps predicted taken, fetch target
// - not taken: discard fetch, one idle slot
// - unconditional jumps take four cycles
// - hub instruction stalls execute, 7 to 22
// - hub window every 16, then execute
module cog_instruction_pipeline import cog_pipe_pkg::*; #(
	parameter int HUB_EXEC_CYCLES = `HUB_EXEC_CYCLES,
	parameter int HUB_ADDR_W = 16
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic ce,
	output mem_cmd_type mem_cmd,
	input wire logic [31:0] mem_rdata,
	output logic hub_req,
	output logic [HUB_ADDR_W-1:0] hub_addr,
	input wire logic hub_grant,
	input wire logic [31:0] hub_rdata,
	output logic [8:0] pc,
	output logic retire
);

	// elaboration-time parameter checks
	// exec_cnt is four bits wide, which bounds HUB_EXEC_CYCLES
	if (HUB_EXEC_CYCLES < 1 || HUB_EXEC_CYCLES > 15) begin : bad_hub_exec
		$error("HUB_EXEC_CYCLES must be 1 to 15");
	end
	if (HUB_ADDR_W < 1 || HUB_ADDR_W > 32) begin : bad_hub_addr
		$error("HUB_ADDR_W must be 1 to 32");
	end

	// slot timing of one instruction n, cycle m being its fetch:
	//   m    fetch n at pc
	//   m+1  write back the result of n-1
	//   m+2  read the source operand, skipped for an immediate
	//   m+3  read the destination operand
	//   m+4  alu settles while n+1 is fetched, so this is m of n+1
	//   m+5  write back the result of n, which is m+1 of n+1
	// two of the six cycles are shared with the neighbours, so the
	// steady state is four cycles a slot.
	// a hub instruction parks between m+3 and m+4 until its window
	// comes round, then spends HUB_EXEC_CYCLES with the memory idle.
	// limitation: no forwarding exists; a result written at m+5 is
	// only seen by an operand read of a later slot, and an instruction
	// that rewrites its direct successor runs the old copy of it.
	// the memory port is one access a cycle, which is why the
	// write-back of n-1 must wait until n has been fetched.

	// sequencer state and the memory command for the next cycle
	phase_type phase;
	phase_type next_phase;
	mem_cmd_type next_cmd;

	// instruction register and the address it came from
	logic [31:0] ir;
	logic ir_valid;
	logic [8:0] cur_pc;
	logic [8:0] next_pc;

	// operands and results; hub_data holds the word the hub returned
	logic [31:0] src_val;
	logic [31:0] dst_val;
	logic [31:0] hub_data;
	logic [31:0] next_result;
	logic next_wb_en;

	// squash drops the predicted fetch of a jump that falls through
	logic squash;
	// counts the hub execute cycles down to one
	logic [3:0] exec_cnt;

	// decoded fields of the instruction register
	op_type op;
	logic imm;
	logic is_jump;

	assign op = op_type'(ir[`OP_HI:`OP_LO]);
	assign imm = ir[`IMM_BIT];
	assign is_jump = (op == op_jump_unconditional) || (op == op_jump_with_return_save) ||
		(op == op_decrement_jump_nonzero);

	// slot sequencer: fetch, write-back of the previous, source, destination
	// the hub states sit between the destination read and the next fetch
	always_comb begin
		next_phase = ph_fetch;
		unique case (phase)
			ph_fetch: next_phase = ph_wback;
			ph_wback: next_phase = ph_src;
			ph_src: next_phase = ph_dst;
			ph_dst: begin
				if (ir_valid && op == op_hub_read) begin
					next_phase = ph_hub_wait;
				end else begin
					next_phase = ph_fetch;
				end
			end
			ph_hub_wait: begin
				// spins until this core's window comes round
				next_phase = hub_grant ? ph_hub_exec : ph_hub_wait;
			end
			ph_hub_exec: begin
				// memory stays idle while the hub word is taken in
				next_phase = (exec_cnt == 4'h1) ? ph_fetch : ph_hub_exec;
			end
			default: next_phase = ph_fetch;
		endcase
	end

	// alu: evaluated during the cycle that also fetches the next instruction
	// every result is ready one cycle before its write-back
	always_comb begin
		next_result = dst_val;
		next_wb_en = ir_valid;
		squash = 1'b0;
		unique case (op)
			op_mov: next_result = src_val;
			op_add: next_result = dst_val + src_val;
			op_sub: next_result = dst_val - src_val;
			op_and: next_result = dst_val & src_val;
			op_or: next_result = dst_val | src_val;
			op_xor: next_result = dst_val ^ src_val;
			op_move_instruction_field: begin
				next_result = {src_val[8:0], dst_val[`INSTR_LO-1:0]};
			end
			op_move_source_field: begin
				next_result = {dst_val[31:`SRC_HI+1], src_val[8:0]};
			end
			op_move_destination_field: begin
				next_result = {dst_val[31:`DST_HI+1], src_val[8:0], dst_val[`SRC_HI:0]};
			end
			op_jump_unconditional: next_wb_en = 1'b0;
			op_jump_with_return_save: begin
				// link address lands in the source field of the destination
				next_result = {dst_val[31:`SRC_HI+1], cur_pc + 9'h001};
			end
			op_decrement_jump_nonzero: begin
				// the fetch of the target is already under way; a zero result
				// throws it away and costs one idle slot
				next_result = dst_val - 32'h1;
				squash = ir_valid && (next_result == 32'h0);
			end
			op_hub_read: next_result = hub_data;
			default: next_wb_en = 1'b0;
		endcase
	end

	// next fetch address: decided once the source operand is known
	// jumps resolve at m+3 from the source operand, so the target is
	// fetched at m+4 with no lost slot; only a fall-through costs one
	always_comb begin
		next_pc = pc;
		if (phase == ph_fetch && squash) begin
			// predicted fetch is discarded, fall through instead
			next_pc = cur_pc + 9'h001;
		end else if (phase == ph_dst && ir_valid) begin
			if (is_jump) begin
				next_pc = src_val[8:0];
			end else begin
				next_pc = cur_pc + 9'h001;
			end
		end
	end

	// memory command for the cycle about to start
	// built one cycle early so the port itself is a register
	always_comb begin
		next_cmd = '0;
		unique case (next_phase)
			ph_fetch: begin
				next_cmd.re = 1'b1;
				next_cmd.addr = next_pc;
			end
			ph_wback: begin
				// write-back trails the fetch, so a rewritten next word is seen stale
				next_cmd.we = next_wb_en;
				next_cmd.addr = ir[`DST_HI:`DST_LO];
				next_cmd.wdata = next_result;
			end
			ph_src: begin
				next_cmd.re = ~imm;
				next_cmd.addr = ir[`SRC_HI:`SRC_LO];
			end
			ph_dst: begin
				next_cmd.re = 1'b1;
				next_cmd.addr = ir[`DST_HI:`DST_LO];
			end
			default: next_cmd = '0;
		endcase
	end

	// state register of the sequencer
	// ce low holds every flop, so a frozen core resumes where it stopped
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			phase <= ph_fetch;
		end else if (ce) begin
			phase <= next_phase;
		end
	end

	// memory port, registered so the pins never glitch
	// reset leaves a fetch of the reset address on the port
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			mem_cmd <= '{re: 1'b1, we: 1'b0, addr: `RESET_PC, wdata: 32'h0};
		end else if (ce) begin
			mem_cmd <= next_cmd;
		end
	end

	// program counter, frozen during a hub stall
	// pc moves only at the end of m+3 and at a squash; the hub stall
	// states leave it alone so the next fetch is not lost
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pc <= `RESET_PC;
		end else if (ce) begin
			pc <= next_pc;
		end
	end

	// instruction capture; a squashed slot runs as a bubble
	// the word fetched at m+4 is captured before the m+5 write, which
	// is why a rewritten successor still runs in its old form
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ir <= 32'h0;
			ir_valid <= 1'b0;
			cur_pc <= `RESET_PC;
		end else if (ce && phase == ph_fetch) begin
			ir <= mem_rdata;
			ir_valid <= ~squash;
			cur_pc <= pc;
		end
	end

	// operand capture
	// an immediate never looks at mem_rdata, whatever the port returns
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			src_val <= 32'h0;
			dst_val <= 32'h0;
		end else if (ce) begin
			if (phase == ph_src) begin
				src_val <= imm ? {23'h0, ir[`SRC_HI:`SRC_LO]} : mem_rdata;
			end
			if (phase == ph_dst) begin
				dst_val <= mem_rdata;
			end
		end
	end

	// hub handshake; request stands for every cycle of the wait
	// the grant is only looked at while the request stands, so a stray
	// grant pulse from the far side is harmless
	// hub_addr is the low part of the source operand, fixed at m+3
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			hub_req <= 1'b0;
			hub_addr <= '0;
			hub_data <= 32'h0;
			exec_cnt <= 4'h0;
		end else if (ce) begin
			hub_req <= (next_phase == ph_hub_wait);
			if (phase == ph_dst) begin
				hub_addr <= src_val[HUB_ADDR_W-1:0];
			end
			if (phase == ph_hub_wait && hub_grant) begin
				hub_data <= hub_rdata;
				exec_cnt <= 4'(HUB_EXEC_CYCLES);
			end else if (phase == ph_hub_exec) begin
				exec_cnt <= exec_cnt - 4'h1;
			end
		end
	end

	// completion pulse in the write-back cycle of each real instruction
	// jumps retire too, although op_jump_unconditional writes nothing
	// a squashed slot never retires
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			retire <= 1'b0;
		end else if (ce) begin
			retire <= (phase == ph_fetch) && ir_valid;
		end
	end

endmodule : cog_instruction_pipeline

/* hdl/cog_pipe_regs.svh */
`ifndef COG_PIPE_REGS_SVH
`define COG_PIPE_REGS_SVH

// instruction word fields
`define OP_HI 31
`define OP_LO 28
`define INSTR_HI 31
`define INSTR_LO 23
`define IMM_BIT 22
`define DST_HI 17
`define DST_LO 9
`define SRC_HI 8
`define SRC_LO 0

// reset values
`define RESET_PC 9'h000

// timing counts, in clock cycles
`define SLOT_CYCLES 4
`define HUB_WINDOW_CYCLES 16
`define HUB_EXEC_CYCLES 2

`endif

/* hdl/cog_pipe_pkg.sv */
package cog_pipe_pkg;

	// one cycle of the slot per state, plus the two hub stall states
	typedef enum logic [5:0] {
		ph_fetch = 6'h01,
		ph_wback = 6'h02,
		ph_src = 6'h04,
		ph_dst = 6'h08,
		ph_hub_wait = 6'h10,
		ph_hub_exec = 6'h20
	} phase_type;

	typedef enum logic [3:0] {
		op_nop = 4'h0,
		op_mov = 4'h1,
		op_add = 4'h2,
		op_sub = 4'h3,
		op_and = 4'h4,
		op_or = 4'h5,
		op_xor = 4'h6,
		op_move_instruction_field = 4'h7,
		op_move_source_field = 4'h8,
		op_move_destination_field = 4'h9,
		op_jump_unconditional = 4'ha,
		op_jump_with_return_save = 4'hb,
		op_decrement_jump_nonzero = 4'hc,
		op_hub_read = 4'hd
	} op_type;

	// one access of the single-ported local memory
	typedef struct packed {
		logic re;
		logic we;
		logic [8:0] addr;
		logic [31:0] wdata;
	} mem_cmd_type;

endpackage : cog_pipe_pkg

/* tb/cog_pipe_monitor.sv */
`timescale 1ns/1ps
module cog_pipe_monitor import cog_pipe_pkg::*; #(
	parameter int HUB_ADDR_W = 16
) (
	input wire logic clk,
	input wire logic rst_b,
	input mem_cmd_type mem_cmd,
	input wire logic hub_req,
	input wire logic [HUB_ADDR_W-1:0] hub_addr,
	input wire logic hub_grant,
	input wire logic [8:0] pc,
	input wire logic retire
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// retire marks the write-back cycle, so every slot is read relative to it
	property p_gap; retire |=> !retire [*3]; endproperty
	a_gap: assert property (p_gap) else $error("retire gap");
	property p_wb; retire |-> $past(mem_cmd.re) && !mem_cmd.re; endproperty
	a_wb: assert property (p_wb) else $error("wback order");
	property p_dst; retire |-> ##2 mem_cmd.re && !mem_cmd.we; endproperty
	a_dst: assert property (p_dst) else $error("dst read");
	property p_we; mem_cmd.we |-> retire; endproperty
	a_we: assert property (p_we) else $error("stray write");
	property p_next; retire |-> ##3 (mem_cmd.re || hub_req); endproperty
	a_next: assert property (p_next) else $error("no next fetch");
	// nothing may move while the hub stalls the execute stage
	property p_hold;
		hub_req && !hub_grant |=> hub_req && $stable(pc) && $stable(hub_addr) && mem_cmd == '0;
	endproperty
	a_hold: assert property (p_hold) else $error("stall leak");
	property p_exec;
		hub_req && hub_grant |=> !hub_req && mem_cmd == '0 ##1 mem_cmd == '0 ##1 mem_cmd.re;
	endproperty
	a_exec: assert property (p_exec) else $error("hub exec");
	property p_win; $rose(hub_req) |-> ##[1:16] !hub_req; endproperty
	a_win: assert property (p_win) else $error("hub wait");
endmodule : cog_pipe_monitor

/* tb/cog_mem_model.sv */
`timescale 1ns/1ps
module cog_mem_model import cog_pipe_pkg::*; (
	input wire logic clk,
	input mem_cmd_type mem_cmd,
	output logic [31:0] mem_rdata,
	input wire logic hub_req,
	input wire logic [15:0] hub_addr,
	output logic hub_grant,
	output logic [31:0] hub_rdata
);
	logic [31:0] mem [512];
	logic [3:0] cyc = 4'h0;
	// idle lines churn so a stale read is never mistaken for data
	assign mem_rdata = mem_cmd.re ? mem[mem_cmd.addr] : {8{cyc}};
	// one hub window in sixteen cycles
	assign hub_grant = hub_req && cyc == 4'h0;
	assign hub_rdata = hub_grant ? {16'h5a5a, hub_addr} : {8{~cyc}};
	// plain always: the bench also preloads this array
	always @(posedge clk) begin
		cyc <= cyc + 4'h1;
		if (mem_cmd.we) mem[mem_cmd.addr] <= mem_cmd.wdata;
	end
endmodule : cog_mem_model

/* tb/cog_instruction_pipeline_bench.sv */
`timescale 1ns/1ps
module cog_instruction_pipeline_bench import cog_pipe_pkg::*;;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	mem_cmd_type mem_cmd;
	logic [31:0] mem_rdata, hub_rdata;
	logic hub_req, hub_grant, retire;
	logic [15:0] hub_addr;
	logic [8:0] pc;
	int error_cnt = 0, compares = 0, cyc = 0, span;
	cog_instruction_pipeline cog_instruction_pipeline_i (.clk, .rst_b, .ce(1'b1), .mem_cmd,
		.mem_rdata, .hub_req, .hub_addr, .hub_grant, .hub_rdata, .pc, .retire);
	cog_mem_model cog_mem_model_i (.clk, .mem_cmd, .mem_rdata, .hub_req, .hub_addr,
		.hub_grant, .hub_rdata);
	// 25 MHz clock and a cycle count for slot timing
	initial forever #20 clk = ~clk;
	always @(posedge clk) cyc <= cyc + 1;
	function automatic logic [31:0] ins(op_type op, logic imm, logic [8:0] d, s);
		return {op, 5'h0, imm, 4'h0, d, s};
	endfunction : ins
	task automatic ld(logic [8:0] a, logic [31:0] d);
		cog_mem_model_i.mem[a] = d;
	endtask : ld
	task automatic chk(logic [31:0] got, exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// run n retires from address zero, then park in reset so loads are safe
	task automatic go(int n);
		int k, t0;
		k = 0;
		repeat (6) @(posedge clk);
		rst_b <= 1'b1;
		while (k < n) begin
			@(negedge clk);
			if (retire === 1'b1) begin
				if (k == 0) t0 = cyc;
				k++;
				span = cyc - t0;
			end
		end
		// let the last write-back land before reset
		@(posedge clk);
		rst_b <= 1'b0;
		@(negedge clk);
	endtask : go
	task automatic s_alu;
		ld(9'h0, ins(op_add, 1'h0, 9'h100, 9'h101));
		ld(9'h1, ins(op_add, 1'h1, 9'h102, 9'h005));
		ld(9'h2, ins(op_jump_unconditional, 1'h1, 9'h0, 9'h002));
		ld(9'h100, 32'h3);
		ld(9'h101, 32'h4);
		ld(9'h102, 32'h1);
		go(4);
		chk(span, 32'hc);
		chk(cog_mem_model_i.mem[9'h100], 32'h7);
		chk(cog_mem_model_i.mem[9'h102], 32'h6);
	endtask : s_alu
	task automatic s_mod;
		ld(9'h0, ins(op_move_source_field, 1'h1, 9'h001, 9'h055));
		ld(9'h1, ins(op_add, 1'h1, 9'h100, 9'h001));
		ld(9'h100, 32'h0);
		go(3);
		chk(cog_mem_model_i.mem[9'h100], 32'h1);
	endtask : s_mod
	task automatic s_loop;
		ld(9'h0, ins(op_decrement_jump_nonzero, 1'h1, 9'h100, 9'h000));
		ld(9'h1, ins(op_jump_unconditional, 1'h1, 9'h0, 9'h001));
		ld(9'h100, 32'h3);
		go(4);
		chk(span, 32'h10);
		chk(cog_mem_model_i.mem[9'h100], 32'h0);
	endtask : s_loop
	task automatic s_hub;
		ld(9'h0, ins(op_hub_read, 1'h1, 9'h100, 9'h034));
		ld(9'h1, ins(op_hub_read, 1'h1, 9'h101, 9'h035));
		ld(9'h2, ins(op_jump_unconditional, 1'h1, 9'h0, 9'h002));
		go(3);
		chk(span >= 11 && span <= 26, 32'h1);
		chk(cog_mem_model_i.mem[9'h101], 32'h5a5a0035);
	endtask : s_hub
	task automatic close_out;
		$display("errors=%0d compares=%0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : close_out
	initial begin
		s_alu;
		s_mod;
		s_loop;
		s_hub;
		close_out;
	end
	// all four runs need well under two hundred cycles
	initial begin
		repeat (3000) @(posedge clk);
		error_cnt++;
		close_out;
	end
endmodule : cog_instruction_pipeline_bench
bind cog_instruction_pipeline cog_pipe_monitor #(.HUB_ADDR_W(HUB_ADDR_W)) cog_pipe_monitor_i (
	.clk, .rst_b, .mem_cmd, .hub_req, .hub_addr, .hub_grant, .pc, .retire);
